// ==== dsi_host_monitor.sv ====
// Purpose: port level checks of the host controller
// Assumes: config follows apb writes
// Notes: mirrors only the registers it needs
`timescale 1ns/1ps
module dsi_host_monitor
  import dsi_host_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pready_o,
  input wire logic video_active_o,
  input wire logic cmd_active_o,
  input wire logic blank_pkt_o,
  input wire logic sync_delay_o
);
  // ****
  // mirror and checks
  // ****
  logic wr;
  logic pw_q, nul_q, mul_q, sp_q;
  logic [15:0] hbp_q;
  assign wr = psel_i && penable_i && pwrite_i;
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pw_q <= 1'b0;
      nul_q <= 1'b0;
      mul_q <= 1'b0;
      sp_q <= 1'b0;
      hbp_q <= hbp_reset;
    end else if (wr) begin
      if (paddr_i == power_up_control_off) pw_q <= pwdata_i[0];
      if (paddr_i == video_mode_config_off) sp_q <= pwdata_i[sync_pulse_bit];
      if (paddr_i == timing_config_off) hbp_q <= pwdata_i[31:16];
      if (paddr_i == packet_handler_config_off) begin
        nul_q <= pwdata_i[null_pkt_en_bit];
        mul_q <= pwdata_i[multi_pkt_en_bit];
      end
    end
  end
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  a_ready_setup: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no ready after setup");
  a_ready_once: assert property (pready_o |=> !pready_o)
    else $error("ready held");
  a_mode_excl: assert property (!(video_active_o && cmd_active_o))
    else $error("both modes active");
  a_modes_held: assert property (pw_q [*5] |-> $stable({video_active_o, cmd_active_o}))
    else $error("mode changed while running");
  a_core_held: assert property (!pw_q [*3] |-> !video_active_o && !cmd_active_o)
    else $error("mode active in reset");
  a_blank_pulse: assert property (blank_pkt_o |=> !blank_pkt_o)
    else $error("blank pulse long");
  a_short_porch: assert property (blank_pkt_o && sp_q |-> hbp_q >= min_blank_bytes)
    else $error("blank in short porch");
  a_delay_gated: assert property (sync_delay_o |-> nul_q && mul_q)
    else $error("null delay without multi");
endmodule
bind dsi_host_video_command_ctrl dsi_host_monitor u_mon (.mclk_i, .rst_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o, .video_active_o,
  .cmd_active_o, .blank_pkt_o, .sync_delay_o);

// ==== dsi_host_pkg.sv ====
// Purpose: shared constants for the display link host controller
// Assumes: 32-bit apb, 40 mhz mclk_i
// Notes: offsets are byte addresses
package dsi_host_pkg;
  localparam logic [11:0] power_up_control_off = 12'h004;
  localparam logic [11:0] video_mode_config_off = 12'h01C;
  localparam logic [11:0] command_mode_config_off = 12'h024;
  localparam logic [11:0] packet_handler_config_off = 12'h02C;
  localparam logic [11:0] timing_config_off = 12'h030;
  localparam logic [11:0] error_status_one_off = 12'h040;
  localparam logic [11:0] error_mask_off = 12'h044;
  localparam logic [11:0] link_status_off = 12'h048;
  localparam int enable_bit = 0;
  localparam int crc_rx_en_bit = 0;
  localparam int null_pkt_en_bit = 1;
  localparam int multi_pkt_en_bit = 2;
  localparam int sync_pulse_bit = 1;
  localparam int crc_err_bit = 0;
  localparam int pkt_done_bit = 1;
  localparam int hsync_start_bytes = 4;
  localparam int min_blank_bytes = 6;
  localparam int long_hdr_bytes = 4;
  localparam logic [7:0] null_delay_bytes = 8'h04;
  localparam logic [15:0] hsa_reset = 16'h000C;
  localparam logic [15:0] hbp_reset = 16'h000C;
  localparam logic [31:0] unmapped_read = 32'h0000_0000;
  typedef enum logic [3:0] {
    st_idle = 4'b0001,
    st_hdr = 4'b0010,
    st_pay = 4'b0100,
    st_crc = 4'b1000
  } rx_state_t;
endpackage

// ==== dsi_host_video_command_ctrl.sv ====
// Purpose: display link host controller register file, mode and timing control
// Assumes: apb slave on mclk_i, link clock sampled as plain input
// Notes: mode enables reach link logic unsynchronised, captured at core release
//
// Contract
// R1: a reverse long packet has its 16-bit crc checked and a mismatch sets crc error.
// R2: a reverse long packet with no payload is accepted without crc error.
// R3: the crc check enable bit off suppresses every crc error.
// R4: video enable is bit 0 at 0x1C and command enable is bit 0 at 0x24.
// R5: mode enables are static and used by link logic without a synchroniser.
// R6: software changes the mode enables only while the core is held in reset.
// R7: power-up register at 0x04 holds the core in reset at 0x00 and runs it at 0x01.
// R8: null packet delay on sync events applies only when multiple packets are enabled.
// R9: software enables null packets only together with multiple packets; the bench line test writes 3, null without multiple.
// R10: with sync pulses no blanking packet goes out when back porch is under 6 bytes.
// R11: sync active and back porch are best programmed above 10 lane byte cycles.
// R12: mode enables are sampled at core release and held until the next reset.
`timescale 1ns/1ps
module dsi_host_video_command_ctrl
  import dsi_host_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic lane_clk_i,
  input wire logic rx_start_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic line_start_i,
  output logic irq_o,
  output logic video_active_o,
  output logic cmd_active_o,
  output logic blank_pkt_o,
  output logic sync_delay_o
);
  // ****************
  // state
  // ****************
  logic pwr_q;
  logic vid_cfg_q;
  logic vid_pulse_q;
  logic cmd_cfg_q;
  logic [2:0] pkt_cfg_q;
  logic [15:0] hsa_q;
  logic [15:0] hbp_q;
  logic [1:0] sts_q;
  logic [1:0] mask_q;
  logic core_rst;
  logic vid_run_q;
  logic cmd_run_q;
  logic cap_q;
  logic [2:0] lclk_q;
  logic [1:0] start_q;
  logic [15:0] byte_q0;
  logic [7:0] rxb_q;
  logic [1:0] ls_q;
  logic ls_prev_q;
  logic [15:0] lcnt_q;
  logic [7:0] dly_q;
  logic in_line_q;
  logic lane_edge;
  logic wr_en;
  logic [1:0] sts_set;
  logic [15:0] porch_end;
  logic line_go;
  logic [31:0] rdata_d;
  rx_link_if rx_res ();

  assign core_rst = rst_i || !pwr_q; // [R7]
  assign wr_en = psel_i && penable_i && pwrite_i;

  // ****************
  // apb registers
  // ****************
  // core reset source, kept apart from the bits it guards
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pwr_q <= 1'b0;
    end else if (wr_en && paddr_i == power_up_control_off) begin
      pwr_q <= pwdata_i[enable_bit]; // [R7]
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      vid_cfg_q <= 1'b0;
      vid_pulse_q <= 1'b0;
      cmd_cfg_q <= 1'b0;
    end else if (wr_en && paddr_i == video_mode_config_off) begin
      vid_cfg_q <= pwdata_i[enable_bit]; // [R4]
      vid_pulse_q <= pwdata_i[sync_pulse_bit];
    end else if (wr_en && paddr_i == command_mode_config_off) begin
      cmd_cfg_q <= pwdata_i[enable_bit]; // [R4]
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pkt_cfg_q <= 3'h1;
      hsa_q <= hsa_reset;
      hbp_q <= hbp_reset;
      mask_q <= 2'h0;
    end else if (wr_en) begin
      unique case (paddr_i)
        packet_handler_config_off: pkt_cfg_q <= pwdata_i[2:0];
        timing_config_off: begin
          hsa_q <= pwdata_i[15:0];
          hbp_q <= pwdata_i[31:16];
        end
        error_mask_off: mask_q <= pwdata_i[1:0];
        default: ;
      endcase
    end
  end

  // ****************
  // sticky status
  // ****************
  assign sts_set[crc_err_bit] = rx_res.crc_err; // [R1]
  assign sts_set[pkt_done_bit] = rx_res.pkt_done;

  // set beats clear when both land in one cycle
  for (genvar g = 0; g < 2; g++) begin : g_sts
    always_ff @(posedge mclk_i) begin
      if (rst_i) begin
        sts_q[g] <= 1'b0;
      end else if (sts_set[g]) begin
        sts_q[g] <= 1'b1;
      end else if (wr_en && paddr_i == error_status_one_off && pwdata_i[g]) begin
        sts_q[g] <= 1'b0;
      end
    end
  end

  always_comb begin
    rdata_d = unmapped_read;
    unique case (paddr_i)
      power_up_control_off: rdata_d = {31'h0, pwr_q};
      video_mode_config_off: rdata_d = {30'h0, vid_pulse_q, vid_cfg_q};
      command_mode_config_off: rdata_d = {31'h0, cmd_cfg_q};
      packet_handler_config_off: rdata_d = {29'h0, pkt_cfg_q};
      timing_config_off: rdata_d = {hbp_q, hsa_q};
      error_status_one_off: rdata_d = {30'h0, sts_q};
      error_mask_off: rdata_d = {30'h0, mask_q};
      link_status_off: rdata_d = {29'h0, in_line_q, cmd_run_q, vid_run_q};
      default: rdata_d = unmapped_read;
    endcase
  end

  // no wait state: pready rises at the setup cycle's closing edge, so the first access cycle completes
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i && !penable_i;
      pslverr_o <= 1'b0;
    end
  end

  // word latched in setup, so it stands with pready
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0000_0000;
    end else begin
      prdata_o <= rdata_d;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(sts_q & mask_q);
    end
  end

  // ****************
  // mode capture
  // ****************
  // deliberately unsynchronised: software moves them only while held [R5] [R6]
  always_ff @(posedge mclk_i) begin
    if (core_rst) begin
      vid_run_q <= 1'b0;
      cmd_run_q <= 1'b0;
      cap_q <= 1'b0;
    end else if (!cap_q) begin
      // one capture only, even with both enables off
      vid_run_q <= vid_cfg_q; // [R12]
      cmd_run_q <= cmd_cfg_q && !vid_cfg_q; // [R12]
      cap_q <= 1'b1;
    end
  end

  // ****************
  // link sampling
  // ****************
  // byte rides the same two stages as the clock, so it lines up with the edge
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      lclk_q <= 3'h0;
    end else begin
      lclk_q <= {lclk_q[1:0], lane_clk_i};
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      start_q <= 2'h0;
    end else begin
      start_q <= {start_q[0], rx_start_i};
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      byte_q0 <= 16'h0000;
    end else begin
      byte_q0 <= {byte_q0[7:0], rx_byte_i};
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ls_q <= 2'h0;
    end else begin
      ls_q <= {ls_q[0], line_start_i};
    end
  end
  assign lane_edge = lclk_q[1] && !lclk_q[2];
  assign rxb_q = byte_q0[15:8];

  dsi_rx_crc u_rx (
    .mclk_i(mclk_i),
    .rst_i(core_rst),
    .crc_en_i(pkt_cfg_q[crc_rx_en_bit]), // [R3]
    .byte_stb_i(lane_edge),
    .start_i(start_q[1]),
    .byte_i(rxb_q),
    .res(rx_res)
  );

  // ****************
  // line timing
  // ****************
  always_ff @(posedge mclk_i) begin
    if (core_rst) begin
      ls_prev_q <= 1'b0;
    end else begin
      ls_prev_q <= ls_q[1];
    end
  end

  // sums past 16 bits wrap: timing fields are meant to stay small
  assign porch_end = 16'(hsa_q + hbp_q);
  assign line_go = ls_q[1] && !ls_prev_q && vid_run_q;

  always_ff @(posedge mclk_i) begin
    if (core_rst) begin
      lcnt_q <= 16'h0000;
      dly_q <= 8'h00;
      in_line_q <= 1'b0;
      blank_pkt_o <= 1'b0;
    end else begin
      blank_pkt_o <= 1'b0;
      if (line_go) begin
        in_line_q <= 1'b1;
        lcnt_q <= 16'h0000;
        // delay only when null and multiple both on [R8]
        if (pkt_cfg_q[null_pkt_en_bit] && pkt_cfg_q[multi_pkt_en_bit]) begin
          dly_q <= null_delay_bytes;
        end else begin
          dly_q <= 8'h00;
        end
      end else if (in_line_q && lane_edge) begin
        if (dly_q != 8'h00) begin
          dly_q <= dly_q - 8'h01;
        end else begin
          lcnt_q <= lcnt_q + 16'h0001;
          if (lcnt_q == hsa_q) begin
            // blanking only when the porch can hold it [R10]
            blank_pkt_o <= vid_pulse_q &&
              (hbp_q >= 16'(min_blank_bytes));
          end
          if (lcnt_q == porch_end) begin
            in_line_q <= 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (core_rst) begin
      sync_delay_o <= 1'b0;
    end else begin
      sync_delay_o <= in_line_q && (dly_q != 8'h00); // [R8]
    end
  end

  always_ff @(posedge mclk_i) begin
    if (core_rst) begin
      video_active_o <= 1'b0;
      cmd_active_o <= 1'b0;
    end else begin
      video_active_o <= vid_run_q;
      cmd_active_o <= cmd_run_q;
    end
  end
endmodule

// ==== dsi_host_video_command_ctrl_bench.sv ====
// Purpose: self-checking bench of the host controller
// Assumes: one word apb accesses
// Notes: lane clock comes from the peer model
`timescale 1ns/1ps
module dsi_host_video_command_ctrl_bench;
  import dsi_host_pkg::*;
  // ****
  // stimulus and checks
  // ****
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic line_start_i = 1'b0;
  logic run_q = 1'b0;
  logic [11:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0;
  logic [31:0] prdata_o, rd_q, d, e;
  logic [15:0] h;
  logic sv_q;
  logic pready_o, pslverr_o, lane_clk_i, rx_start_i, irq_o;
  logic video_active_o, cmd_active_o, blank_pkt_o, sync_delay_o;
  logic [7:0] rx_byte_i;
  int err_count = 0;
  int tests_run = 0;
  int n, nb, nd;
  initial forever #12.5 mclk_i = !mclk_i;
  dsi_host_video_command_ctrl u_dut (.mclk_i, .rst_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .lane_clk_i, .rx_start_i,
    .rx_byte_i, .line_start_i, .irq_o, .video_active_o, .cmd_active_o, .blank_pkt_o,
    .sync_delay_o);
  dsi_peer_model u_peer (.run_i(run_q), .lane_clk_o(lane_clk_i), .start_o(rx_start_i),
    .byte_o(rx_byte_i));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    tests_run++;
    if (g !== x) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", s, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
    int k;
    k = 0;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= v;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge mclk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 64);
    if (k == 64) err_count++;
    rd_q = prdata_o;
    sv_q = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), x, rd_q);
    chk("slverr", 32'h0, sv_q);
  endtask
  // mode bits only move while the core is held
  task automatic cfg(input logic [31:0] v, input logic [31:0] c, input logic [31:0] t);
    apb(1'b1, power_up_control_off, 32'h0);
    apb(1'b1, timing_config_off, t);
    apb(1'b1, video_mode_config_off, v);
    apb(1'b1, command_mode_config_off, c);
    apb(1'b1, power_up_control_off, 32'h1);
    repeat (4) @(posedge mclk_i);
  endtask
  initial begin
    repeat (40000) @(posedge mclk_i);
    err_count++;
    report_and_stop;
  end
  initial begin
    void'($urandom(32'h0C3E1BB7));
    repeat (6) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    rchk(packet_handler_config_off, 32'h1);
    rchk(timing_config_off, {hbp_reset, hsa_reset});
    rchk(error_status_one_off, 32'h0);
    rchk(12'h3FC, unmapped_read);
    repeat (3) begin
      d = $urandom;
      apb(1'b1, timing_config_off, d);
      rchk(timing_config_off, d);
    end
    $display("test regs done");
    for (int i = 0; i < 4; i++) begin
      cfg(i[0], i[1], {hbp_reset, hsa_reset});
      chk("video", i[0], video_active_o);
      chk("cmd", i[1] & !i[0], cmd_active_o);
    end
    apb(1'b1, power_up_control_off, 32'h0);
    repeat (4) @(posedge mclk_i);
    chk("held", 32'h0, {video_active_o, cmd_active_o});
    $display("test modes done");
    cfg(32'h0, 32'h1, {hbp_reset, hsa_reset});
    apb(1'b1, error_mask_off, 32'h1);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, packet_handler_config_off, i < 3);
      n = (i > 1 && i % 2 == 0) ? 0 : 1 + $urandom % 8;
      u_peer.send(n, i == 1 || i == 3);
      repeat (30) @(posedge mclk_i);
      e = (32'h1 << pkt_done_bit) | ((i == 1) << crc_err_bit);
      rchk(error_status_one_off, e);
      chk("irq", i == 1, irq_o);
      apb(1'b1, error_status_one_off, 32'h3);
      rchk(error_status_one_off, 32'h0);
    end
    $display("test crc done");
    run_q <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      h = (i == 0) ? 16'h0004 : 16'h000C;
      cfg(32'h3, 32'h0, {h, 16'h000C});
      apb(1'b1, packet_handler_config_off, (i == 0) ? 7 : (i == 1) ? 3 : 5);
      nb = 0;
      nd = 0;
      line_start_i <= 1'b1;
      repeat (600) begin
        @(posedge mclk_i);
        nb += blank_pkt_o;
        nd += sync_delay_o;
      end
      line_start_i <= 1'b0;
      chk("blank", i > 0, nb > 0);
      chk("delay", i == 0, nd > 0);
    end
    $display("test line done");
    report_and_stop;
  end
endmodule

// ==== dsi_peer_model.sv ====
// Purpose: display peripheral sending reverse packets
// Assumes: lane clock 200 ns, idle low outside frames while run_i is low
// Notes: payload drawn from the caller's seeded stream
`timescale 1ns/1ps
module dsi_peer_model (
  input wire logic run_i,
  output logic lane_clk_o,
  output logic start_o,
  output logic [7:0] byte_o
);
  // ****
  // link side
  // ****
  logic busy = 1'b0;
  initial begin
    lane_clk_o = 1'b0;
    start_o = 1'b0;
    byte_o = 8'hA5;
    #37;
    forever begin
      #100;
      lane_clk_o = (run_i || busy) ? !lane_clk_o : 1'b0;
    end
  end
  function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] b);
    c = c ^ {8'h00, b};
    for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
    return c;
  endfunction
  // bytes change on the falling edge, away from sampling
  task automatic put(input logic [7:0] b, input logic s);
    @(negedge lane_clk_o);
    byte_o = b;
    start_o = s;
  endtask
  task automatic send(input int n, input logic bad);
    logic [15:0] c;
    logic [7:0] b;
    c = 16'hFFFF;
    busy = 1'b1;
    put(8'h1A, 1'b1);
    put(n[7:0], 1'b0);
    put(n[15:8], 1'b0);
    put(8'h00, 1'b0);
    for (int i = 0; i < n; i++) begin
      b = $urandom;
      put(b, 1'b0);
      c = crc(c, b);
    end
    if (bad) c = ~c;
    put(c[7:0], 1'b0);
    put(c[15:8], 1'b0);
    // released line shows the inverse, not a stale byte
    put(~c[15:8], 1'b0);
    busy = 1'b0;
  endtask
endmodule

// ==== dsi_rx_crc.sv ====
// Purpose: reverse packet receiver with payload crc check
// Assumes: byte stream sampled on link clock edges found by the caller
// Notes: crc is ccitt polynomial, lsb first, seed 16'hFFFF
`timescale 1ns/1ps
module dsi_rx_crc
  import dsi_host_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic crc_en_i,
  input wire logic byte_stb_i,
  input wire logic start_i,
  input wire logic [7:0] byte_i,
  rx_link_if.rx res
);
  rx_state_t state_q;
  logic [1:0] hcnt_q;
  logic [15:0] wc_q;
  logic [15:0] crc_q;
  logic [15:0] rcv_q;
  logic crc_hi_q;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (r[0] ^ d[i]) begin
        r = (r >> 1) ^ 16'h8408;
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction

  // ****************
  // packet walker
  // ****************
  always_ff @(posedge mclk_i) begin
    res.crc_err <= 1'b0;
    res.pkt_done <= 1'b0;
    if (rst_i) begin
      state_q <= st_idle;
      hcnt_q <= 2'h0;
      wc_q <= 16'h0000;
      crc_q <= 16'hFFFF;
      rcv_q <= 16'h0000;
      crc_hi_q <= 1'b0;
    end else if (byte_stb_i) begin
      unique case (state_q)
        st_idle: begin
          if (start_i) begin
            state_q <= st_hdr;
            hcnt_q <= 2'h1;
            crc_q <= 16'hFFFF;
          end
        end
        st_hdr: begin
          hcnt_q <= hcnt_q + 2'h1;
          if (hcnt_q == 2'h1) begin
            wc_q[7:0] <= byte_i;
          end
          if (hcnt_q == 2'h2) begin
            wc_q[15:8] <= byte_i;
          end
          if (hcnt_q == 2'h3) begin
            // zero payload: nothing to check, done [R2]
            if (wc_q == 16'h0000) begin
              state_q <= st_idle;
              res.pkt_done <= 1'b1;
            end else begin
              state_q <= st_pay;
            end
          end
        end
        st_pay: begin
          crc_q <= crc_step(crc_q, byte_i); // [R1]
          wc_q <= wc_q - 16'h0001;
          if (wc_q == 16'h0001) begin
            state_q <= st_crc;
            crc_hi_q <= 1'b0;
          end
        end
        st_crc: begin
          crc_hi_q <= 1'b1;
          if (!crc_hi_q) begin
            rcv_q[7:0] <= byte_i;
          end else begin
            state_q <= st_idle;
            res.pkt_done <= 1'b1;
            // flag only when checking is on [R1] [R3]
            res.crc_err <= crc_en_i && ({byte_i, rcv_q[7:0]} != crc_q);
          end
        end
        default: state_q <= st_idle;
      endcase
    end
  end
endmodule

// ==== rx_link_if.sv ====
// Purpose: carries reverse packet results from receiver to core
// Assumes: all on mclk_i
// Notes: pulses last one cycle
`timescale 1ns/1ps
interface rx_link_if;
  logic crc_err;
  logic pkt_done;
  modport rx (output crc_err, output pkt_done);
  modport core (input crc_err, input pkt_done);
endinterface
